// ==== inc/plc_mode_map.vh ====
// Purpose: constants for the mode and scan controller
// Assumes: 40 MHz ref_clk, 10 ms system tick
// Notes: register offsets are byte addresses on a 32-bit bus
`ifndef PLC_MODE_MAP_VH
`define PLC_MODE_MAP_VH
`define CLK_KHZ 40000
`define TICK_MS 10
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define HALT_POLL_MS 50
`define HALT_POLL_TICKS (`HALT_POLL_MS / `TICK_MS)
`define PERIOD_MAX_UNITS 8'h14
`define MODE_HALT 3'h0
`define MODE_RUN 3'h1
`define MODE_RUNF 3'h2
`define MODE_HOLD 3'h3
`define MODE_DEBUG 3'h4
`define MODE_ERROR 3'h5
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_CMD 5'h08
`define REG_SCAN_TIME 5'h0C
`define REG_EXEC_TIME 5'h10
`define CMD_HALT 0
`define CMD_RUN 1
`define CMD_FORCE 2
`define CMD_HOLD 3
`define CMD_DEBUG 4
`define CMD_ERR_RST 5
`define ST_OVERRUN 3
`define ST_CONST 4
`define ST_FIRST 5
`define STEP_LOAD 3'h0
`define STEP_INIT 3'h1
`define STEP_IOCHK 3'h2
`define STEP_PCHK 3'h3
`define STEP_IO 3'h4
`define STEP_TIMER 3'h5
`define STEP_EXEC 3'h6
`define BLINK_TICKS 8'h19
`endif

// ==== testbench/plc_mode_and_scan_control_tb.sv ====
// Purpose: mode controller bench
// Assumes: 20 cycles per tick
// Notes: Avalon-MM master
`timescale 1ns/1ps
`include "plc_mode_map.vh"
module plc_mode_and_scan_control_tb;
    localparam TC = 20;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg clk_en = 1'b1;
    reg [4:0] avs_address = 5'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h00000000;
    reg mode_switch_run = 1'b1;
    reg dip_protect = 1'b0;
    reg dip_rom_ram = 1'b0;
    reg dip_standby = 1'b0;
    reg diag_fatal = 1'b0;
    reg eeprom_has_program = 1'b1;
    reg eeprom_bcc_ok = 1'b1;
    reg ram_bcc_ok = 1'b1;
    reg module_absent = 1'b0;
    reg module_mismatch = 1'b0;
    reg [7:0] direct_mask = 8'h00;
    reg [7:0] force_mask = 8'h00;
    reg [7:0] exec_delay = 8'h02;
    wire step_done, step_req, outputs_enable, avs_waitrequest, fault_indicator;
    wire [2:0] step_sel, mode;
    wire [7:0] in_load_sel, out_send_sel, timer_ticks, timing_relay_bits;
    wire [31:0] avs_readdata;
    wire [11:0] start_log;
    reg [31:0] rd;
    integer errors = 0;
    integer n_checks = 0;
    integer cyc = 0;
    plc_mode_and_scan_control #(.TICK_CYCLES(TC)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mode_switch_run(mode_switch_run), .dip_protect(dip_protect), .dip_rom_ram(dip_rom_ram),
        .dip_standby(dip_standby), .diag_fatal(diag_fatal), .eeprom_has_program(eeprom_has_program),
        .eeprom_bcc_ok(eeprom_bcc_ok), .ram_bcc_ok(ram_bcc_ok), .module_absent(module_absent),
        .module_mismatch(module_mismatch), .direct_mask(direct_mask), .force_mask(force_mask),
        .step_done(step_done), .step_req(step_req), .step_sel(step_sel),
        .outputs_enable(outputs_enable), .in_load_sel(in_load_sel), .out_send_sel(out_send_sel),
        .timer_ticks(timer_ticks), .timing_relay_bits(timing_relay_bits), .mode(mode),
        .fault_indicator(fault_indicator)
    );
    step_partner i_partner (
        .ref_clk(ref_clk), .rst_n(rst_n), .step_req(step_req), .step_sel(step_sel),
        .exec_delay(exec_delay), .step_done(step_done), .start_log_reg(start_log)
    );
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            errors = errors + 1;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////
    task final_report;
    begin
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task check(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task bus(input wr, input [4:0] a, input [31:0] d);
    begin
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask
    task cmd(input integer b);
        bus(1'b1, `REG_CMD, 32'h00000001 << b);
    endtask
    task wait_mode(input [2:0] m, input integer lim);
        integer k;
    begin
        k = 0;
        while (mode !== m && k < lim)
        begin
            tick(1);
            k = k + 1;
        end
        check({29'h0, mode}, {29'h0, m});
    end
    endtask
    ////////////////////////////////////////////////////////////
    task t_power_on;
    begin
        wait_mode(`MODE_RUN, 400);
        tick(60);
        check({20'h0, start_log}, 32'h00000053);
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd & 32'h00000017, 32'h00000001);
        bus(1'b0, 5'h14, 32'h0);
        check(rd, 32'h00000000);
    end
    endtask
    task t_switch;
    begin
        @(posedge ref_clk) mode_switch_run <= 1'b0;
        wait_mode(`MODE_HALT, 400);
        check({31'h0, outputs_enable}, 32'h0);
        cmd(`CMD_RUN);
        tick(300);
        wait_mode(`MODE_HALT, 1);
        direct_mask <= 8'hA5;
        force_mask <= 8'h0C;
        @(posedge ref_clk) mode_switch_run <= 1'b1;
        wait_mode(`MODE_RUN, 5 * TC + 80);
    end
    endtask
    task t_commands;
        reg f;
    begin
        cmd(`CMD_HOLD);
        wait_mode(`MODE_HOLD, 200);
        rd = {24'h0, timing_relay_bits};
        tick(4 * TC);
        check({24'h0, timing_relay_bits}, rd);
        cmd(`CMD_HALT);
        wait_mode(`MODE_HALT, 200);
        module_absent <= 1'b1;
        cmd(`CMD_FORCE);
        wait_mode(`MODE_RUNF, 400);
        cmd(`CMD_HALT);
        wait_mode(`MODE_HALT, 200);
        module_absent <= 1'b0;
        module_mismatch <= 1'b1;
        cmd(`CMD_FORCE);
        tick(400);
        check({31'h0, mode === `MODE_RUNF}, 32'h0);
        module_mismatch <= 1'b0;
        if (mode === `MODE_ERROR)
            cmd(`CMD_ERR_RST);
        wait_mode(`MODE_HALT, 300);
        cmd(`CMD_RUN);
        wait_mode(`MODE_RUN, 300);
        cmd(`CMD_DEBUG);
        wait_mode(`MODE_DEBUG, 200);
        f = fault_indicator;
        tick(30 * TC);
        check({31'h0, fault_indicator !== f}, 32'h1);
        cmd(`CMD_HALT);
        wait_mode(`MODE_HALT, 300);
    end
    endtask
    task t_fatal;
    begin
        @(posedge ref_clk) diag_fatal <= 1'b1;
        tick(2);
        diag_fatal <= 1'b0;
        wait_mode(`MODE_ERROR, 10);
        cmd(`CMD_HALT);
        tick(300);
        wait_mode(`MODE_ERROR, 1);
        cmd(`CMD_ERR_RST);
        wait_mode(`MODE_HALT, 300);
    end
    endtask
    task t_bad_eeprom;
    begin
        eeprom_bcc_ok <= 1'b0;
        cmd(`CMD_RUN);
        wait_mode(`MODE_ERROR, 400);
        eeprom_bcc_ok <= 1'b1;
        cmd(`CMD_ERR_RST);
        wait_mode(`MODE_HALT, 300);
    end
    endtask
    task t_const;
    begin
        bus(1'b1, `REG_CTRL, 32'h00000001);
        exec_delay <= 8'h3C;
        cmd(`CMD_RUN);
        wait_mode(`MODE_RUN, 400);
        tick(300);
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd & 32'h00000008, 32'h00000008);
        exec_delay <= 8'h00;
        tick(100);
        bus(1'b1, `REG_STATUS, 32'h00000008);
        tick(100);
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd & 32'h00000018, 32'h00000010);
        check({24'h0, timer_ticks}, 32'h1);
    end
    endtask
    task t_standby;
    begin
        @(posedge ref_clk);
        dip_standby <= 1'b1;
        rst_n <= 1'b0;
        tick(10);
        rst_n <= 1'b1;
        tick(400);
        wait_mode(`MODE_HALT, 1);
    end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        tick(10);
        rst_n <= 1'b1;
        tick(3);
        t_power_on;
        t_switch;
        t_commands;
        t_fatal;
        t_bad_eeprom;
        t_const;
        t_standby;
        final_report;
    end
endmodule // plc_mode_and_scan_control_tb

// ==== testbench/plc_mode_monitor.sv ====
// Purpose: port checks of the mode controller
// Assumes: one clock domain
// Notes: bound below
`timescale 1ns/1ps
`include "plc_mode_map.vh"
module plc_mode_monitor (
    input wire ref_clk,
    input wire rst_n,
    input wire diag_fatal,
    input wire [7:0] direct_mask,
    input wire [7:0] force_mask,
    input wire step_done,
    input wire step_req,
    input wire [2:0] step_sel,
    input wire outputs_enable,
    input wire [7:0] in_load_sel,
    input wire [7:0] out_send_sel,
    input wire [2:0] mode,
    input wire fault_indicator
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_init_done;
        step_done && step_sel == `STEP_INIT;
    endsequence
    sequence s_iochk_req;
        step_req && step_sel == `STEP_IOCHK;
    endsequence
    sequence s_pchk_done;
        step_done && step_sel == `STEP_PCHK;
    endsequence
    sequence s_io_req;
        step_req && step_sel == `STEP_IO;
    endsequence
    property p_start_order;
        s_init_done |-> ##[1:8] s_iochk_req;
    endproperty
    property p_first_out;
        s_pchk_done ##[1:8] s_io_req |-> out_send_sel == 8'h00;
    endproperty
    property p_halt_quiet;
        mode == `MODE_HALT |-> !outputs_enable;
    endproperty
    property p_halt_no_scan;
        $rose(step_req) && step_sel >= `STEP_IO |-> mode != `MODE_HALT;
    endproperty
    property p_error_quiet;
        mode == `MODE_ERROR |-> !outputs_enable && fault_indicator;
    endproperty
    property p_fatal;
        diag_fatal && mode != `MODE_ERROR |-> ##[1:4] mode == `MODE_ERROR;
    endproperty
    property p_error_exit;
        mode != `MODE_ERROR && $past(mode) == `MODE_ERROR |-> mode == `MODE_HALT;
    endproperty
    property p_hold_io;
        $rose(step_req) && mode == `MODE_HOLD |-> step_sel == `STEP_IO;
    endproperty
    property p_in_sel;
        s_io_req |-> in_load_sel == (~direct_mask & ~force_mask);
    endproperty
    property p_out_sel;
        s_io_req and outputs_enable |-> out_send_sel == ~direct_mask;
    endproperty
    ////////////////////////////////////////////////////////////
    a_start_order: assert property (p_start_order)
        else $error("start order");
    a_first_out: assert property (p_first_out)
        else $error("first scan out");
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("halt out");
    a_halt_no_scan: assert property (p_halt_no_scan)
        else $error("halt scan");
    a_error_quiet: assert property (p_error_quiet)
        else $error("error out");
    a_fatal: assert property (p_fatal)
        else $error("fatal");
    a_error_exit: assert property (p_error_exit)
        else $error("error exit");
    a_hold_io: assert property (p_hold_io)
        else $error("hold step");
    a_in_sel: assert property (p_in_sel)
        else $error("in select");
    a_out_sel: assert property (p_out_sel)
        else $error("out select");
endmodule // plc_mode_monitor

bind plc_mode_and_scan_control plc_mode_monitor i_mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .diag_fatal(diag_fatal),
    .direct_mask(direct_mask), .force_mask(force_mask), .step_done(step_done),
    .step_req(step_req), .step_sel(step_sel), .outputs_enable(outputs_enable),
    .in_load_sel(in_load_sel), .out_send_sel(out_send_sel), .mode(mode),
    .fault_indicator(fault_indicator)
);

// ==== testbench/step_partner.sv ====
// Purpose: far side answering steps
// Assumes: step_req holds until step_done
// Notes: exec_delay stretches scans
`timescale 1ns/1ps
`include "plc_mode_map.vh"
module step_partner (
    input wire ref_clk,
    input wire rst_n,
    input wire step_req,
    input wire [2:0] step_sel,
    input wire [7:0] exec_delay,
    output reg step_done,
    output reg [11:0] start_log_reg
);
    reg [7:0] cnt_reg;
    wire [7:0] lim = (step_sel == `STEP_EXEC) ? exec_delay : 8'h02;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 8'h00;
            step_done <= 1'b0;
            start_log_reg <= 12'h000;
        end
        else if (step_done)
        begin
            step_done <= 1'b0;
            cnt_reg <= 8'h00;
            if (step_sel < `STEP_IO)
                start_log_reg <= {start_log_reg[8:0], step_sel};
        end
        else if (step_req && cnt_reg >= lim)
            step_done <= 1'b1;
        else if (step_req)
            cnt_reg <= cnt_reg + 8'h01;
    end
endmodule // step_partner

// ==== verilog/plc_mode_and_scan_control.v ====
// Purpose: operating-mode selection and scan sequencing for a PLC CPU
// Assumes: all inputs synchronous to ref_clk; step_done answers step_req
// Notes: registers over Avalon-MM, answer on second edge of a request
// Function
// - halted mode forces outputs off and stops program and module exchange.
// - halted mode checks for mode changes every 50 ms.
// - run start-up runs load, data init, module check, program check, scan mode.
// - run mode loops mode control, batch exchange, timer update, program execution.
// - forced run tolerates absent modules but not a wrong module type.
// - scan hold keeps batch exchange only and keeps the scan mode.
// - unrecoverable diagnostic error enters error mode with outputs off.
// - in error mode only error reset acts, returning to halt.
// - power-on enters run if switch at run and stand-by off, else halt.
// - switch to run from halt gives run; switch to halt halts in every mode but error.
// - peripheral commands other than error reset act only with switch at run.
// - debug mode blinks the fault indicator.
// - with protect and rom/ram switches off, start-up loads program and data words.
// - with protect and rom/ram switches off, a stored program with bad check code skips load and enters error.
// - program in main memory is checked before scanning.
// - first scan after entering run does inputs only.
// - floating scan starts the next scan at once.
// - constant scan starts scans every 10 to 200 ms in 10 ms steps.
// - an overrun falls back to floating until scans fit and sets the overrun flag until a write of one clears it.
// - no configured period means floating scan.
// - batch exchange skips forced inputs and modules marked for direct access.
// - mode control samples switch and commands, paces and measures the scan.
// - timer update adds elapsed 10 ms ticks; timing relay bits advance on each tick of the scan loop in every run-type mode but hold.
`timescale 1ns/1ps
`include "plc_mode_map.vh"
module plc_mode_and_scan_control #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire mode_switch_run,
    input wire dip_protect,
    input wire dip_rom_ram,
    input wire dip_standby,
    input wire diag_fatal,
    input wire eeprom_has_program,
    input wire eeprom_bcc_ok,
    input wire ram_bcc_ok,
    input wire module_absent,
    input wire module_mismatch,
    input wire [7:0] direct_mask,
    input wire [7:0] force_mask,
    input wire step_done,
    output reg step_req,
    output reg [2:0] step_sel,
    output reg outputs_enable,
    output reg [7:0] in_load_sel,
    output reg [7:0] out_send_sel,
    output reg [7:0] timer_ticks,
    output reg [7:0] timing_relay_bits,
    output reg [2:0] mode,
    output reg fault_indicator
);

////////////////////////////////////////////////////////////////////////
// reset release and 10 ms tick

reg rst_meta_reg;
reg rst_sync_reg;
always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end
    else
    begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

reg [31:0] tick_cnt_reg;
wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
always @(posedge ref_clk or negedge rst_sync_reg)
begin
    if (!rst_sync_reg)
        tick_cnt_reg <= 32'h0;
    else if (clk_en)
        tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
end

////////////////////////////////////////////////////////////////////////
// state machine codes

localparam [10:0] S_POR = 11'h001;
localparam [10:0] S_HALT = 11'h002;
localparam [10:0] S_LOAD = 11'h004;
localparam [10:0] S_INIT = 11'h008;
localparam [10:0] S_IOCHK = 11'h010;
localparam [10:0] S_PCHK = 11'h020;
localparam [10:0] S_MODE = 11'h040;
localparam [10:0] S_IO = 11'h080;
localparam [10:0] S_TIMER = 11'h100;
localparam [10:0] S_EXEC = 11'h200;
localparam [10:0] S_ERROR = 11'h400;

// run-type modes share the scan loop
function is_running;
    input [2:0] m;
    begin
        is_running = (m == `MODE_RUN) || (m == `MODE_RUNF) || (m == `MODE_HOLD) || (m == `MODE_DEBUG);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// registers and bus slave

reg [10:0] state_reg;
reg [7:0] period_reg;
reg [5:0] cmd_pend_reg;
reg overrun_flag_reg;
reg overrun_active_reg;
reg const_mode_reg;
reg first_scan_reg;
reg [7:0] scan_time_reg;
reg [15:0] exec_time_reg;
reg [15:0] exec_cnt_reg;
reg [7:0] scan_ticks_reg;
reg [7:0] halt_ticks_reg;
reg [7:0] blink_reg;
reg switch_prev_reg;

wire bus_req = avs_read | avs_write;
wire bus_take = bus_req & ~avs_waitrequest;
wire wr_ctrl = bus_take & avs_write & (avs_address == `REG_CTRL);
wire wr_status = bus_take & avs_write & (avs_address == `REG_STATUS);
wire wr_cmd = bus_take & avs_write & (avs_address == `REG_CMD);

// out-of-range periods are clipped to the top value
wire [7:0] period_wr = (avs_writedata[7:0] > `PERIOD_MAX_UNITS) ? `PERIOD_MAX_UNITS : avs_writedata[7:0];

reg [31:0] rd_mux;
always @*
begin
    rd_mux = 32'h0;
    case (avs_address)
        `REG_CTRL: rd_mux = {24'h0, period_reg};
        `REG_STATUS: rd_mux = {26'h0, first_scan_reg, const_mode_reg & ~overrun_active_reg,
                               overrun_flag_reg, mode};
        `REG_CMD: rd_mux = {26'h0, cmd_pend_reg};
        `REG_SCAN_TIME: rd_mux = {24'h0, scan_time_reg};
        `REG_EXEC_TIME: rd_mux = {16'h0, exec_time_reg};
        default: rd_mux = 32'h0;
    endcase
end

always @(posedge ref_clk or negedge rst_sync_reg)
begin
    if (!rst_sync_reg)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h0;
        period_reg <= 8'h0;
    end
    else if (clk_en)
    begin
        avs_waitrequest <= ~(bus_req & avs_waitrequest);
        if (bus_req & avs_waitrequest)
            avs_readdata <= avs_read ? rd_mux : 32'h0;
        if (wr_ctrl)
            period_reg <= period_wr;
    end
end

////////////////////////////////////////////////////////////////////////
// mode decision

wire poll_now = (state_reg != S_HALT) || (halt_ticks_reg >= `HALT_POLL_TICKS);
wire sw_to_run = mode_switch_run & ~switch_prev_reg;
wire sw_to_halt = ~mode_switch_run & switch_prev_reg;
wire cmd_ok = mode_switch_run;
wire step_busy = step_req;

reg [2:0] next_mode;
always @*
begin
    next_mode = mode;
    if (mode == `MODE_ERROR)
    begin
        if (cmd_pend_reg[`CMD_ERR_RST])
            next_mode = `MODE_HALT;
    end
    else if (~mode_switch_run)
        next_mode = `MODE_HALT;
    else if (cmd_ok & cmd_pend_reg[`CMD_HALT])
        next_mode = `MODE_HALT;
    else if (mode == `MODE_HALT)
    begin
        if (sw_to_run | (cmd_ok & cmd_pend_reg[`CMD_RUN]))
            next_mode = `MODE_RUN;
        else if (cmd_ok & cmd_pend_reg[`CMD_FORCE])
            next_mode = `MODE_RUNF;
    end
    else if (cmd_ok & cmd_pend_reg[`CMD_HOLD])
        next_mode = `MODE_HOLD;
    else if (cmd_ok & cmd_pend_reg[`CMD_DEBUG])
        next_mode = `MODE_DEBUG;
    else if (cmd_ok & cmd_pend_reg[`CMD_RUN])
        next_mode = `MODE_RUN;
end

wire apply_mode = poll_now & ((state_reg == S_HALT) || (state_reg == S_MODE) || (state_reg == S_ERROR));

////////////////////////////////////////////////////////////////////////
// main sequencer

reg [10:0] state_next;
reg [2:0] mode_next;
reg go_step;
reg [2:0] go_sel;
always @*
begin
    state_next = state_reg;
    mode_next = mode;
    go_step = 1'b0;
    go_sel = `STEP_LOAD;
    case (state_reg)
        S_POR:
        begin
            if (mode_switch_run & ~dip_standby)
            begin
                state_next = S_LOAD;
                mode_next = `MODE_RUN;
            end
            else
                state_next = S_HALT;
        end
        S_HALT:
        begin
            if (apply_mode && is_running(next_mode))
            begin
                state_next = S_LOAD;
                mode_next = next_mode;
            end
        end
        S_LOAD:
        begin
            if (~dip_protect & ~dip_rom_ram & eeprom_has_program & ~eeprom_bcc_ok)
                state_next = S_ERROR;
            else if (~dip_protect & ~dip_rom_ram)
            begin
                go_step = ~step_busy;
                go_sel = `STEP_LOAD;
                if (step_done)
                    state_next = S_INIT;
            end
            else
                state_next = S_INIT;
        end
        S_INIT:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_INIT;
            if (step_done)
                state_next = S_IOCHK;
        end
        S_IOCHK:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_IOCHK;
            if (step_done)
            begin
                if (module_mismatch || (module_absent && mode != `MODE_RUNF))
                    state_next = S_ERROR;
                else
                    state_next = S_PCHK;
            end
        end
        S_PCHK:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_PCHK;
            if (step_done)
                state_next = ram_bcc_ok ? S_MODE : S_ERROR;
        end
        S_MODE:
        begin
            if (apply_mode && !is_running(next_mode))
            begin
                state_next = (next_mode == `MODE_ERROR) ? S_ERROR : S_HALT;
                mode_next = next_mode;
            end
            else if (~const_mode_reg | overrun_active_reg | (scan_ticks_reg >= period_reg))
            begin
                state_next = S_IO;
                if (apply_mode)
                    mode_next = next_mode;
            end
        end
        S_IO:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_IO;
            if (step_done)
                state_next = (mode == `MODE_HOLD) ? S_MODE : S_TIMER;
        end
        S_TIMER:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_TIMER;
            if (step_done)
                state_next = S_EXEC;
        end
        S_EXEC:
        begin
            go_step = ~step_busy;
            go_sel = `STEP_EXEC;
            if (step_done)
                state_next = S_MODE;
        end
        S_ERROR:
        begin
            mode_next = `MODE_ERROR;
            if (apply_mode && next_mode == `MODE_HALT)
            begin
                state_next = S_HALT;
                mode_next = `MODE_HALT;
            end
        end
        default:
            state_next = S_POR;
    endcase
    if (diag_fatal && state_reg != S_ERROR && state_reg != S_POR)
    begin
        state_next = S_ERROR;
        mode_next = `MODE_ERROR;
    end
    if (state_next == S_ERROR)
        mode_next = `MODE_ERROR;
    if (state_next == S_HALT)
        mode_next = `MODE_HALT;
end

// end of a scan is the move from exec or hold-io into mode control
wire scan_end = (state_next == S_MODE) && (state_reg == S_EXEC || state_reg == S_IO);
wire scan_start = (state_reg == S_MODE) && (state_next == S_IO);
wire leave_step = step_busy & step_done;

always @(posedge ref_clk or negedge rst_sync_reg)
begin
    if (!rst_sync_reg)
    begin
        state_reg <= S_POR;
        mode <= `MODE_HALT;
        step_req <= 1'b0;
        step_sel <= `STEP_LOAD;
        cmd_pend_reg <= 6'h0;
        switch_prev_reg <= 1'b0;
        halt_ticks_reg <= 8'h0;
    end
    else if (clk_en)
    begin
        state_reg <= state_next;
        mode <= mode_next;
        // halted: the switch is sampled only at the poll so a move to run is not lost
        if (state_reg != S_HALT || apply_mode)
            switch_prev_reg <= mode_switch_run;
        if (leave_step)
            step_req <= 1'b0;
        else if (go_step)
        begin
            step_req <= 1'b1;
            step_sel <= go_sel;
        end
        if (state_reg != S_HALT || apply_mode)
            halt_ticks_reg <= 8'h0;
        else if (tick)
            halt_ticks_reg <= halt_ticks_reg + 8'h1;
        // a command written in the cycle it is consumed stays pending
        cmd_pend_reg <= (apply_mode ? 6'h0 : cmd_pend_reg) | (wr_cmd ? avs_writedata[5:0] : 6'h0);
    end
end

////////////////////////////////////////////////////////////////////////
// scan timing, measurement and overrun

always @(posedge ref_clk or negedge rst_sync_reg)
begin
    if (!rst_sync_reg)
    begin
        scan_ticks_reg <= 8'h0;
        scan_time_reg <= 8'h0;
        exec_cnt_reg <= 16'h0;
        exec_time_reg <= 16'h0;
        const_mode_reg <= 1'b0;
        overrun_active_reg <= 1'b0;
        overrun_flag_reg <= 1'b0;
        first_scan_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        if (state_reg == S_PCHK)
        begin
            const_mode_reg <= (period_reg != 8'h0);
            overrun_active_reg <= 1'b0;
            first_scan_reg <= 1'b1;
            scan_ticks_reg <= 8'h0;
        end
        else if (scan_start)
        begin
            scan_time_reg <= scan_ticks_reg;
            scan_ticks_reg <= tick ? 8'h1 : 8'h0;
        end
        else if (tick && scan_ticks_reg != 8'hFF)
            scan_ticks_reg <= scan_ticks_reg + 8'h1;
        if (scan_end)
        begin
            first_scan_reg <= 1'b0;
            if (const_mode_reg)
                overrun_active_reg <= (scan_ticks_reg > period_reg);
        end
        if (state_reg == S_EXEC)
        begin
            if (exec_cnt_reg != 16'hFFFF)
                exec_cnt_reg <= exec_cnt_reg + 16'h1;
        end
        else if (state_reg == S_MODE && exec_cnt_reg != 16'h0)
        begin
            exec_time_reg <= exec_cnt_reg;
            exec_cnt_reg <= 16'h0;
        end
        // hardware set wins over a software write-one clear
        if (scan_end && const_mode_reg && scan_ticks_reg > period_reg)
            overrun_flag_reg <= 1'b1;
        else if (wr_status && avs_writedata[`ST_OVERRUN])
            overrun_flag_reg <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// outputs toward modules, timers and panel

wire in_run = is_running(mode) && (state_reg & (S_MODE | S_IO | S_TIMER | S_EXEC)) != 11'h0;

always @(posedge ref_clk or negedge rst_sync_reg)
begin
    if (!rst_sync_reg)
    begin
        outputs_enable <= 1'b0;
        in_load_sel <= 8'h0;
        out_send_sel <= 8'h0;
        timer_ticks <= 8'h0;
        timing_relay_bits <= 8'h0;
        fault_indicator <= 1'b0;
        blink_reg <= 8'h0;
    end
    else if (clk_en)
    begin
        // next-state view so outputs drop in the same cycle the mode leaves run
        outputs_enable <= is_running(mode_next) && ((state_next & (S_MODE | S_IO | S_TIMER | S_EXEC)) != 11'h0)
                          && ~first_scan_reg;
        in_load_sel <= (state_next == S_IO) ? ~direct_mask & ~force_mask : 8'h0;
        out_send_sel <= (state_next == S_IO && !first_scan_reg) ? ~direct_mask : 8'h0;
        if (state_reg == S_PCHK)
            timing_relay_bits <= 8'h0;
        else if (tick && in_run && mode != `MODE_HOLD)
            timing_relay_bits <= timing_relay_bits + 8'h1;
        if (state_next == S_TIMER && state_reg != S_TIMER)
            timer_ticks <= scan_time_reg;
        if (mode_next == `MODE_ERROR)
        begin
            blink_reg <= 8'h0;
            fault_indicator <= 1'b1;
        end
        else if (mode == `MODE_DEBUG)
        begin
            if (tick)
                blink_reg <= (blink_reg >= `BLINK_TICKS - 8'h1) ? 8'h0 : blink_reg + 8'h1;
            if (tick && blink_reg >= `BLINK_TICKS - 8'h1)
                fault_indicator <= ~fault_indicator;
        end
        else
        begin
            blink_reg <= 8'h0;
            fault_indicator <= 1'b0;
        end
    end
end

endmodule // plc_mode_and_scan_control
